// *** core/fcc_top.sv ***
// Frame checker statistics bank: live counters, read-clear error count, snapshots

`timescale 1ns/100ps
module fcc_top
  import fcc_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                RSTN,
  // AXI4-Lite write address channel
  input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  // AXI4-Lite write data channel
  input  wire logic [DATA_W-1:0]   S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  // AXI4-Lite write response channel
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  // AXI4-Lite read address channel
  input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  // AXI4-Lite read data channel
  output logic [DATA_W-1:0]        S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  // Frame streams on the block clock
  input  fcc_pkg::fcc_stream_t     PHY_RX_STREAM,
  input  fcc_pkg::fcc_stream_t     MAC_TX_STREAM,
  // Level interrupt
  output logic                     IRQ
);
  import fcc_pkg::*;

  // Register strobes from the bus front end
  logic              wr_stb;      // One-cycle write strobe
  logic [IDX_W-1:0]  wr_idx;      // Register index of the write
  logic [DATA_W-1:0] wr_data;     // Write data
  logic [3:0]        wr_be;       // Byte enables of the write
  logic              rd_stb;      // One-cycle read strobe
  logic [IDX_W-1:0]  rd_idx;      // Register index of the read
  logic [DATA_W-1:0] rd_data;     // Data for the read, sampled by the front end

  // Control registers
  logic              enable_r;    // Checker enable
  logic              src_sel_r;   // Stream source select
  logic [N_IRQ-1:0]  irq_mask_r;  // Interrupt mask, one enables
  logic [N_IRQ-1:0]  irq_stat_r;  // Sticky interrupt status
  logic [N_IRQ-1:0]  irq_stat_nxt;

  // Interrupt output
  logic              irq_r;       // Registered interrupt line

  // Counters and snapshots
  logic [FRM_W-1:0]  frames_r;                 // Live received-frame count
  logic [CNT_W-1:0]  live_err_r [N_ERR];       // Live per-class error counts
  logic [CNT_W-1:0]  snap_err_r [N_ERR];       // Snapshots of the class counts
  logic [CNT_W-1:0]  snap_frm_hi_r;            // Snapshot of frame count high half
  logic [CNT_W-1:0]  snap_frm_lo_r;            // Snapshot of frame count low half
  logic [CNT_W-1:0]  rx_err_r;                 // Receive error count, read-clear
  logic [CNT_W-1:0]  rx_err_nxt;

  // Frame path
  fcc_stream_t       sel_stream;  // Stream chosen for checking
  fcc_frame_evt_t    frame_evt;   // End-of-frame report
  logic              count_en;    // A finished frame that is to be counted
  logic              frame_bad;   // The counted frame carried any error

  // Read events
  logic              snap_take;   // Read of the error count this cycle
  logic              stat_rd;     // Read of the interrupt status this cycle

  // True when a strobe hits a given register index
  function automatic logic idx_hit(input logic stb, input logic [IDX_W-1:0] idx,
                                   input logic [IDX_W-1:0] target);
    idx_hit = stb & (idx == target);
  endfunction

  // Bus front end
  fcc_axil_slave u_bus (
    .clk     (CLK),
    .rst_n   (RSTN),

    // Write address and data
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),

    // Write response
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),

    // Read address and data
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),

    // Register side strobes
    .wr_stb  (wr_stb),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .wr_be   (wr_be),
    .rd_stb  (rd_stb),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  // Source choice; switching mid-frame splices two streams, so software
  // should change it only while the checker is idle
  assign sel_stream = src_sel_r ? MAC_TX_STREAM : PHY_RX_STREAM;

  // Frame measurement
  fcc_frame_mon u_mon (
    .clk   (CLK),
    .rst_n (RSTN),
    .strm  (sel_stream),
    .evt   (frame_evt)
  );

  // Counting gate and read events
  assign count_en  = frame_evt.done & enable_r;
  assign frame_bad = |frame_evt.err;
  assign snap_take = idx_hit(rd_stb, rd_idx, IDX_RX_ERR);
  assign stat_rd   = idx_hit(rd_stb, rd_idx, IDX_IRQ_STAT);

  // Enable bit, resets to one
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      enable_r <= RST_ENABLE;
    end else if (idx_hit(wr_stb, wr_idx, IDX_ENABLE) && wr_be[0]) begin
      enable_r <= wr_data[0];
    end
  end

  // Source select bit
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      src_sel_r <= RST_SRC_SEL;
    end else if (idx_hit(wr_stb, wr_idx, IDX_SRC_SEL) && wr_be[0]) begin
      src_sel_r <= wr_data[0];
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_mask_r <= RST_MASK;
    end else if (idx_hit(wr_stb, wr_idx, IDX_IRQ_MASK) && wr_be[0]) begin
      irq_mask_r <= wr_data[N_IRQ-1:0];
    end
  end

  // Live frame total; wraps rather than saturates
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      frames_r <= RST_FRAMES;
    end else if (count_en) begin
      frames_r <= frames_r + 32'h0000_0001;
    end
  end

  // Live class counters, one per error kind, all wrapping
  genvar gi;
  generate
    for (gi = 0; gi < N_ERR; gi++) begin : g_err
      // Class counter
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          live_err_r[gi] <= RST_COUNT;
        end else if (count_en && frame_evt.err[gi]) begin
          live_err_r[gi] <= live_err_r[gi] + 16'h0001;
        end
      end

      // Class snapshot; takes the pre-increment value of this cycle
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          snap_err_r[gi] <= RST_COUNT;
        end else if (snap_take) begin
          snap_err_r[gi] <= live_err_r[gi];
        end
      end
    end
  endgenerate

  // One strobe, so snapshots share one instant
  // Frame total snapshot, both halves in the same cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      snap_frm_hi_r <= RST_COUNT;
      snap_frm_lo_r <= RST_COUNT;
    end else if (snap_take) begin
      snap_frm_hi_r <= frames_r[FRM_W-1:CNT_W];
      snap_frm_lo_r <= frames_r[CNT_W-1:0];
    end
  end

  // Receive error count next value; a bad frame in the cycle of the
  // clearing read survives as a count of one
  always_comb begin
    rx_err_nxt = rx_err_r;
    if (count_en && frame_bad) begin
      // Clear and count in one cycle
      if (snap_take) begin
        rx_err_nxt = 16'h0001;
      end else begin
        rx_err_nxt = rx_err_r + 16'h0001;
      end
    end else if (snap_take) begin
      // Plain clear after the read
      rx_err_nxt = RST_COUNT;
    end
  end

  // Receive error count register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_err_r <= RST_COUNT;
    end else begin
      rx_err_r <= rx_err_nxt;
    end
  end

  // Interrupt status: set beats the read-clear of the same cycle
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    // Read clears first
    if (stat_rd) begin
      irq_stat_nxt = '0;
    end
    // Events after, so set wins
    if (count_en) begin
      irq_stat_nxt[N_ERR-1:0] = irq_stat_nxt[N_ERR-1:0] | frame_evt.err;
      irq_stat_nxt[IRQ_FRAME] = 1'b1;
      irq_stat_nxt[IRQ_RXERR] = irq_stat_nxt[IRQ_RXERR] | frame_bad;
    end
  end

  // Status register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Interrupt line, one cycle behind the status it reflects
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign IRQ = irq_r;

  // Read data; snapshot reads have no side effect, unmapped reads give zero
  always_comb begin
    rd_data = '0;
    case (rd_idx)
      // Control bits
      IDX_ENABLE: begin
        rd_data[0] = enable_r;
      end
      IDX_SRC_SEL: begin
        rd_data[0] = src_sel_r;
      end

      // Read-clear count
      IDX_RX_ERR: begin
        rd_data[CNT_W-1:0] = rx_err_r;
      end

      // Frame total halves
      IDX_FRM_HIGH: begin
        rd_data[CNT_W-1:0] = snap_frm_hi_r;
      end
      IDX_FRM_LOW: begin
        rd_data[CNT_W-1:0] = snap_frm_lo_r;
      end

      // Class snapshots
      IDX_LEN_ERR: begin
        rd_data[CNT_W-1:0] = snap_err_r[EVT_LEN];
      end
      IDX_ALGN_ERR: begin
        rd_data[CNT_W-1:0] = snap_err_r[EVT_ALGN];
      end
      IDX_SYMB_ERR: begin
        rd_data[CNT_W-1:0] = snap_err_r[EVT_SYMB];
      end
      IDX_OVERSIZE: begin
        rd_data[CNT_W-1:0] = snap_err_r[EVT_OSZ];
      end
      IDX_UNDERSIZE: begin
        rd_data[CNT_W-1:0] = snap_err_r[EVT_USZ];
      end

      // Interrupt words
      IDX_IRQ_STAT: begin
        rd_data[N_IRQ-1:0] = irq_stat_r;
      end
      IDX_IRQ_MASK: begin
        rd_data[N_IRQ-1:0] = irq_mask_r;
      end

      // Unmapped index
      default: begin
        rd_data = '0;
      end
    endcase
  end
endmodule

// *** shared/fcc_pkg.sv ***
// Shared constants and types of the frame checker counter bank
package fcc_pkg;
  localparam int DATA_W = 32;            // Register bus data width
  localparam int ADDR_W = 18;            // Byte address width, covers four times the top index
  localparam int IDX_W  = 16;            // Width of a register index
  localparam int CNT_W  = 16;            // Width of each error counter and snapshot
  localparam int FRM_W  = 32;            // Width of the live received-frame counter
  localparam int LEN_W  = 11;            // Frame byte counter width, saturates above the oversize limit

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_ENABLE    = 16'h8001;
  localparam logic [IDX_W-1:0] IDX_SRC_SEL   = 16'h8005;
  localparam logic [IDX_W-1:0] IDX_RX_ERR    = 16'h8008;
  localparam logic [IDX_W-1:0] IDX_FRM_HIGH  = 16'h8009;
  localparam logic [IDX_W-1:0] IDX_FRM_LOW   = 16'h800A;
  localparam logic [IDX_W-1:0] IDX_LEN_ERR   = 16'h800B;
  localparam logic [IDX_W-1:0] IDX_ALGN_ERR  = 16'h800C;
  localparam logic [IDX_W-1:0] IDX_SYMB_ERR  = 16'h800D;
  localparam logic [IDX_W-1:0] IDX_OVERSIZE  = 16'h800E;
  localparam logic [IDX_W-1:0] IDX_UNDERSIZE = 16'h800F;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 16'h8040;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 16'h8041;

  // Frame length limits in bytes
  localparam logic [LEN_W-1:0] MAX_FRAME_BYTES = 11'h5F2;   // 1522
  localparam logic [LEN_W-1:0] MIN_FRAME_BYTES = 11'h040;   // 64

  // Error event positions inside the per-frame error vector
  localparam int EVT_LEN  = 0;
  localparam int EVT_ALGN = 1;
  localparam int EVT_SYMB = 2;
  localparam int EVT_OSZ  = 3;
  localparam int EVT_USZ  = 4;
  localparam int N_ERR    = 5;
  // Interrupt status bits above the error events
  localparam int IRQ_FRAME = 5;
  localparam int IRQ_RXERR = 6;
  localparam int N_IRQ     = 7;

  // Reset values
  localparam logic             RST_ENABLE  = 1'b1;
  localparam logic             RST_SRC_SEL = 1'b0;
  localparam logic [CNT_W-1:0] RST_COUNT   = 16'h0000;
  localparam logic [FRM_W-1:0] RST_FRAMES  = 32'h0000_0000;
  localparam logic [N_IRQ-1:0] RST_MASK    = 7'h00;

  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;

  // Frame stream from one source, same clock as the block
  typedef struct packed {
    logic dv;        // Frame data valid, high for the whole frame
    logic byte_stb;  // One byte of the frame in this cycle
    logic er;        // Receive error alongside dv
    logic len_err;   // Length error status of the frame
    logic algn_err;  // Alignment error status of the frame
  } fcc_stream_t;

  // One finished frame with its error classes
  typedef struct packed {
    logic             done;
    logic [N_ERR-1:0] err;
  } fcc_frame_evt_t;
endpackage

// *** core/fcc_frame_mon.sv ***
// Frame monitor: measures one frame stream and reports each finished frame
`timescale 1ns/100ps
module fcc_frame_mon
  import fcc_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  fcc_pkg::fcc_stream_t strm,
  output fcc_pkg::fcc_frame_evt_t evt
);
  logic                 in_frame_r;  // High while a frame is under way
  logic [LEN_W-1:0]     len_r;       // Bytes seen so far, saturating
  logic [N_ERR-1:0]     flag_r;      // Sticky status flags of this frame
  fcc_frame_evt_t       evt_r;       // Registered end-of-frame report
  logic                 frame_end;   // Falling edge of dv

  assign frame_end = in_frame_r & ~strm.dv;
  assign evt       = evt_r;

  // Frame activity follows dv
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame_r <= 1'b0;
    end else begin
      in_frame_r <= strm.dv;
    end
  end

  // Byte length; saturation keeps a runaway frame above the oversize limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_r <= '0;
    end else if (strm.dv && !in_frame_r) begin
      len_r <= {{(LEN_W-1){1'b0}}, strm.byte_stb};
    end else if (strm.dv && strm.byte_stb && len_r != {LEN_W{1'b1}}) begin
      len_r <= len_r + 11'h001;
    end
  end

  // Status flags gathered over the frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= '0;
    end else if (strm.dv) begin
      flag_r[EVT_LEN]  <= (in_frame_r & flag_r[EVT_LEN]) | strm.len_err;
      flag_r[EVT_ALGN] <= (in_frame_r & flag_r[EVT_ALGN]) | strm.algn_err;
      flag_r[EVT_SYMB] <= (in_frame_r & flag_r[EVT_SYMB]) | strm.er;
      flag_r[EVT_OSZ]  <= 1'b0;
      flag_r[EVT_USZ]  <= 1'b0;
    end
  end

  // One-cycle report after the frame ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_r <= '0;
    end else begin
      evt_r.done <= frame_end;
      evt_r.err  <= '0;
      if (frame_end) begin
        evt_r.err[EVT_LEN]  <= flag_r[EVT_LEN];
        evt_r.err[EVT_ALGN] <= flag_r[EVT_ALGN];
        evt_r.err[EVT_SYMB] <= flag_r[EVT_SYMB];
        evt_r.err[EVT_OSZ]  <= (len_r > MAX_FRAME_BYTES);
        evt_r.err[EVT_USZ]  <= (len_r < MIN_FRAME_BYTES);
      end
    end
  end
endmodule

// *** core/fcc_axil_slave.sv ***
// AXI4-Lite slave front end: turns bus transfers into register strobes
`timescale 1ns/100ps
module fcc_axil_slave
  import fcc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wr_stb,
  output logic [IDX_W-1:0]       wr_idx,
  output logic [DATA_W-1:0]      wr_data,
  output logic [3:0]             wr_be,
  output logic                   rd_stb,
  output logic [IDX_W-1:0]       rd_idx,
  input  wire logic [DATA_W-1:0] rd_data
);
  logic              aw_held_r;   // Write address captured
  logic              w_held_r;    // Write data captured
  logic              rd_pend_r;   // Read address captured, data due
  logic [ADDR_W-1:0] awaddr_r;
  logic [ADDR_W-1:0] araddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic              rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic              arready_r;   // Address ready, a flop

  assign awready = ~aw_held_r;
  assign wready  = ~w_held_r;
  assign arready = arready_r;
  assign bvalid  = bvalid_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign bresp   = AXI_RESP_OKAY;
  assign rresp   = AXI_RESP_OKAY;
  // Strobes last one cycle because bvalid_r rises and rd_pend_r drops on the next edge
  assign wr_stb  = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_idx  = awaddr_r[ADDR_W-1:2];
  assign wr_data = wdata_r;
  assign wr_be   = wstrb_r;
  assign rd_stb  = rd_pend_r;
  assign rd_idx  = araddr_r[ADDR_W-1:2];

  // Write address and data in either order, response after both
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
    end else begin
      if (awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= awaddr;
      end
      if (wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (wr_stb) begin
        bvalid_r <= 1'b1;
      end else if (bvalid_r && bready) begin
        bvalid_r  <= 1'b0;
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
      end
    end
  end

  // Read: capture address, fetch data next cycle, hold until rready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_r <= 1'b0;
      araddr_r  <= '0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      arready_r <= 1'b1;
    end else begin
      if (arvalid && arready) begin
        rd_pend_r <= 1'b1;
        araddr_r  <= araddr;
        arready_r <= 1'b0;
      end else if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_data;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end
endmodule

// *** verif/fcc_top_properties.sv ***
// Register bus timing and response checker of the statistics bank
`timescale 1ns/100ps
module fcc_top_properties
  import fcc_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RSTN,
  input wire logic              S_AXI_AWVALID,
  input wire logic              S_AXI_AWREADY,
  input wire logic              S_AXI_WVALID,
  input wire logic              S_AXI_WREADY,
  input wire logic [1:0]        S_AXI_BRESP,
  input wire logic              S_AXI_BVALID,
  input wire logic              S_AXI_BREADY,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic [DATA_W-1:0] S_AXI_RDATA,
  input wire logic [1:0]        S_AXI_RRESP,
  input wire logic              S_AXI_RVALID,
  input wire logic              S_AXI_RREADY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Both write channels taken at one edge
  sequence wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // Read address taken
  sequence rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  // Data two edges after the address; a late strobe would skew the snapshot
  rd_latency_a: assert property (rd_take |=> !S_AXI_RVALID && !S_AXI_ARREADY ##1 S_AXI_RVALID)
    else $error("read answer at wrong cycle");
  wr_latency_a: assert property (wr_take |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer at wrong cycle");
  rd_done_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read not closed after handshake");
  wr_done_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY)
    else $error("write not closed after handshake");
  rd_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("second read taken while answering");
  data_width_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
  rresp_okay_a: assert property (S_AXI_RVALID |-> S_AXI_RRESP == AXI_RESP_OKAY)
    else $error("read response not okay");
  bresp_okay_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == AXI_RESP_OKAY)
    else $error("write response not okay");
endmodule
bind fcc_top fcc_top_properties u_props (.CLK, .RSTN, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);

// *** verif/fcc_stream_src.sv ***
// Frame source model for the receive and MAC-side streams
`timescale 1ns/100ps
module fcc_stream_src
(
  input  wire logic            clk,
  output fcc_pkg::fcc_stream_t phy,
  output fcc_pkg::fcc_stream_t mac
);
  import fcc_pkg::*;
  fcc_stream_t fr = '0;       // Word of the frame in flight
  logic        on_phy = 1'b0; // Frame on receive side
  logic        on_mac = 1'b0; // Frame on MAC side
  logic        tgl = 1'b0;    // Idle toggle so no stale flag looks held
  // Idle lines keep changing instead of holding the last value
  always @(posedge clk) tgl <= ~tgl;
  assign phy = on_phy ? fr : {1'b0, {4{tgl}}};
  assign mac = on_mac ? fr : {1'b0, {4{tgl}}};
  // One frame of n bytes; slow gives a byte every second cycle
  task automatic send(input logic to_mac, input int n, input logic [2:0] f, input logic slow);
    @(posedge clk);
    on_phy <= !to_mac;
    on_mac <= to_mac;
    for (int i = 0; i < n; i++) begin
      if (slow) begin
        fr <= {1'b1, 4'h0};
        @(posedge clk);
      end
      fr <= {1'b1, 1'b1, f[2] && i == 1, f[1] && i == n - 1, f[0] && i == 0};
      @(posedge clk);
    end
    on_phy <= 1'b0;
    on_mac <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule

// *** verif/fcc_top_tb.sv ***
// Self-checking bench of the frame checker statistics bank
`timescale 1ns/100ps
module fcc_top_tb;
  import fcc_pkg::*;
  logic              clk = 1'b0;    // Block clock
  logic              rstn = 1'b0;   // Reset, active low
  logic [ADDR_W-1:0] awaddr = '0;   // Write byte address
  logic [ADDR_W-1:0] araddr = '0;   // Read byte address
  logic [DATA_W-1:0] wdata = '0;    // Write data
  logic [DATA_W-1:0] rdata;         // Read data
  logic [1:0]        bresp;         // Write response
  logic [1:0]        rresp;         // Read response
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  fcc_stream_t       phy;
  fcc_stream_t       mac;
  int                checks = 0;
  int                bad_count = 0;
  fcc_top u_fcc_top (.CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PHY_RX_STREAM(phy),
    .MAC_TX_STREAM(mac), .IRQ(irq));
  fcc_stream_src src_m (.clk(clk), .phy(phy), .mac(mac));
  initial forever #50 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
    logic a;
    logic w;
    a = 1'b1;
    w = 1'b1;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (a && awready) begin
        a = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (a || w);
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  // Read one word and compare it
  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp);
  endtask
  // Reset values, read-only and unmapped places
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rdc(IDX_RX_ERR + 16'(i), 32'h0000_0000);
    rdc(IDX_ENABLE, 32'h0000_0001);
    rdc(IDX_SRC_SEL, 32'h0000_0000);
    wr(IDX_LEN_ERR, 32'h0000_FFFF);
    rdc(IDX_LEN_ERR, 32'h0000_0000);
    rdc(16'h8030, 32'h0000_0000);
    $display("t_reset done");
  endtask
  // Every error class once, the size classes at their length boundaries
  task automatic t_counts;
    src_m.send(1'b0, 64, 3'b000, 1'b0);
    src_m.send(1'b0, 63, 3'b000, 1'b1);
    src_m.send(1'b0, 1523, 3'b000, 1'b0);
    src_m.send(1'b0, 1522, 3'b000, 1'b0);
    src_m.send(1'b0, 80, 3'b100, 1'b0);
    src_m.send(1'b0, 80, 3'b010, 1'b0);
    src_m.send(1'b0, 80, 3'b001, 1'b0);
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    rdc(IDX_RX_ERR, 32'h0000_0005);
    rdc(IDX_FRM_HIGH, 32'h0000_0000);
    rdc(IDX_FRM_LOW, 32'h0000_0007);
    rdc(IDX_LEN_ERR, 32'h0000_0001);
    rdc(IDX_ALGN_ERR, 32'h0000_0001);
    rdc(IDX_SYMB_ERR, 32'h0000_0001);
    rdc(IDX_OVERSIZE, 32'h0000_0001);
    rdc(IDX_UNDERSIZE, 32'h0000_0001);
    $display("t_counts done");
  endtask
  // Snapshot holds until the next error-count read
  task automatic t_snap;
    src_m.send(1'b0, 64, 3'b000, 1'b0);
    repeat (4) @(posedge clk);
    rdc(IDX_FRM_LOW, 32'h0000_0007);
    rdc(IDX_FRM_LOW, 32'h0000_0007);
    rdc(IDX_RX_ERR, 32'h0000_0000);
    rdc(IDX_FRM_LOW, 32'h0000_0008);
    rdc(IDX_LEN_ERR, 32'h0000_0001);
    $display("t_snap done");
  endtask
  // Disabled checker counts nothing
  task automatic t_enable;
    wr(IDX_ENABLE, 32'h0000_0000);
    src_m.send(1'b0, 63, 3'b111, 1'b0);
    repeat (4) @(posedge clk);
    wr(IDX_ENABLE, 32'h0000_0001);
    rdc(IDX_RX_ERR, 32'h0000_0000);
    rdc(IDX_FRM_LOW, 32'h0000_0008);
    $display("t_enable done");
  endtask
  // MAC side selected, receive side ignored
  task automatic t_select;
    wr(IDX_SRC_SEL, 32'h0000_0001);
    src_m.send(1'b0, 64, 3'b100, 1'b0);
    src_m.send(1'b1, 64, 3'b100, 1'b0);
    repeat (4) @(posedge clk);
    wr(IDX_SRC_SEL, 32'h0000_0000);
    rdc(IDX_RX_ERR, 32'h0000_0001);
    rdc(IDX_FRM_LOW, 32'h0000_0009);
    rdc(IDX_SYMB_ERR, 32'h0000_0002);
    $display("t_select done");
  endtask
  // Interrupt masked, raised and cleared by reading status
  task automatic t_irq;
    rdc(IDX_IRQ_STAT, 32'h0000_007F);
    rdc(IDX_IRQ_STAT, 32'h0000_0000);
    wr(IDX_IRQ_MASK, 32'h0000_0040);
    src_m.send(1'b0, 64, 3'b001, 1'b0);
    repeat (4) @(posedge clk);
    chk(32'(irq), 32'h0000_0001);
    rdc(IDX_IRQ_STAT, 32'h0000_0062);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    $display("t_irq done");
  endtask
  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Run is about 4100 cycles; cut off well beyond
  initial begin
    #2ms;
    bad_count++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_counts;
    t_snap;
    t_enable;
    t_select;
    t_irq;
    end_of_test;
  end
endmodule
